// File: rtl/rail_fault_pkg.sv
// package: register map, field layout, reset values and timing of the rail fault response block
package rail_fault_pkg;
    localparam logic [7:0] ADDR_RESP_CTRL = 8'hB3;
    localparam logic [7:0] ADDR_FLYBACK_CTRL = 8'hB4;
    localparam logic [7:0] ADDR_RAIL_STATUS = 8'hD3;
    localparam logic [7:0] RESP_CTRL_RESET = 8'h00;
    localparam logic [7:0] FLYBACK_CTRL_RESET = 8'h00;
    localparam logic [7:0] FLYBACK_CTRL_WMASK = 8'hB3;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int SIX_OV_LSB = 4;
    localparam int SIX_UV_LSB = 6;
    localparam int FLY_SHORT_BIT = 7;
    localparam int AVG_OC_LSB = 4;
    localparam int FLY_OC_LSB = 0;
    localparam int STAT_SIX_OV_BIT = 0;
    localparam int STAT_SIX_UV_BIT = 1;
    localparam logic [1:0] CODE_FLAG = 2'h0;
    localparam logic [1:0] CODE_HICCUP = 2'h1;
    localparam logic [1:0] CODE_LATCH = 2'h2;
    localparam logic [1:0] CODE_FLAG_ALT = 2'h3;
    localparam logic [6:0] PMBUS_DEV_ADDR = 7'h40;
    localparam int CLK_HZ = 100000000;
    localparam int HICCUP_DELAY_MS = 500;
    localparam int HICCUP_CYCLES = HICCUP_DELAY_MS * (CLK_HZ / 1000);
endpackage

// File: rtl/pmbus_reg_if.sv
// interface: byte register access between the pmbus slave and the register bank
`timescale 1ns/1ns
interface pmbus_reg_if;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic scl_in;
    logic sda_in;
    logic sda_oe_n;
    modport slave (output wr, output addr, output wdata, output sda_oe_n,
        input rdata, input scl_in, input sda_in);
    modport regs (input wr, input addr, input wdata, input sda_oe_n,
        output rdata, output scl_in, output sda_in);
endinterface

// File: rtl/pmbus_byte_slave.sv
// module: pmbus byte slave, one command byte then one or more data bytes written or read
`timescale 1ns/1ns
module pmbus_byte_slave #(
    parameter logic [6:0] DEV_ADDR = rail_fault_pkg::PMBUS_DEV_ADDR
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    pmbus_reg_if.slave bus
);
    typedef enum logic [2:0] {P_IDLE, P_ADDR, P_CMD, P_WDATA, P_ACK, P_RDATA, P_RACK} pst_t;
    typedef struct packed {
        pst_t st;
        pst_t ret;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] cmd;
        logic wr;
        logic oe_n;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
    } pstate_t;

    pstate_t s;
    pstate_t next_s;
    logic scl_new;
    logic sda_new;
    logic rise;
    logic fall;

    assign bus.wr = s.wr;
    assign bus.addr = s.cmd;
    assign bus.wdata = s.shreg;
    assign bus.sda_oe_n = s.oe_n;

    always_comb begin
        next_s = s;
        next_s.wr = 1'b0;
        next_s.scl_s = {s.scl_s[1:0], bus.scl_in};
        next_s.sda_s = {s.sda_s[1:0], bus.sda_in};
        scl_new = (s.scl_s[1] == s.scl_s[2]) ? s.scl_s[2] : s.scl_f;
        sda_new = (s.sda_s[1] == s.sda_s[2]) ? s.sda_s[2] : s.sda_f;
        next_s.scl_f = scl_new;
        next_s.sda_f = sda_new;
        rise = scl_new & ~s.scl_f;
        fall = ~scl_new & s.scl_f;
        if (s.scl_f && scl_new && s.sda_f && !sda_new) begin
            next_s.st = P_ADDR;
            next_s.bitcnt = 4'h0;
            next_s.oe_n = 1'b1;
        end else if (s.scl_f && scl_new && !s.sda_f && sda_new) begin
            next_s.st = P_IDLE;
            next_s.oe_n = 1'b1;
        end else if (rise) begin
            case (s.st)
                P_ADDR, P_CMD, P_WDATA: begin
                    next_s.shreg = {s.shreg[6:0], sda_new};
                    next_s.bitcnt = s.bitcnt + 4'h1;
                end
                P_RDATA: next_s.bitcnt = s.bitcnt + 4'h1;
                P_RACK: begin
                    next_s.st = sda_new ? P_IDLE : P_ACK;
                    next_s.ret = P_RDATA;
                end
                default: next_s.st = s.st;
            endcase
        end else if (fall) begin
            case (s.st)
                P_ADDR: if (s.bitcnt == 4'h8) begin
                    next_s.bitcnt = 4'h0;
                    if (s.shreg[7:1] == DEV_ADDR) begin
                        next_s.oe_n = 1'b0;
                        next_s.st = P_ACK;
                        next_s.ret = s.shreg[0] ? P_RDATA : P_CMD;
                    end else begin
                        next_s.st = P_IDLE;
                    end
                end
                P_CMD: if (s.bitcnt == 4'h8) begin
                    next_s.cmd = s.shreg;
                    next_s.bitcnt = 4'h0;
                    next_s.oe_n = 1'b0;
                    next_s.st = P_ACK;
                    next_s.ret = P_WDATA;
                end
                P_WDATA: if (s.bitcnt == 4'h8) begin
                    next_s.wr = 1'b1;
                    next_s.bitcnt = 4'h0;
                    next_s.oe_n = 1'b0;
                    next_s.st = P_ACK;
                    next_s.ret = P_WDATA;
                end
                P_ACK: begin
                    next_s.st = s.ret;
                    next_s.bitcnt = 4'h0;
                    if (s.ret == P_RDATA) begin
                        next_s.shreg = bus.rdata;
                        next_s.oe_n = bus.rdata[7];
                    end else begin
                        next_s.oe_n = 1'b1;
                    end
                end
                P_RDATA: if (s.bitcnt == 4'h8) begin
                    next_s.oe_n = 1'b1;
                    next_s.st = P_RACK;
                end else begin
                    next_s.shreg = {s.shreg[6:0], 1'b0};
                    next_s.oe_n = s.shreg[6];
                end
                default: next_s.st = s.st;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{st: P_IDLE, ret: P_IDLE, bitcnt: 4'h0, shreg: 8'h00, cmd: 8'h00,
                wr: 1'b0, oe_n: 1'b1, scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1};
        end else begin
            s <= next_s;
        end
    end
endmodule

// File: rtl/rail_fault_response_select.sv
// module: six-volt rail fault response selection with its pmbus register bank
`timescale 1ns/1ns
module rail_fault_response_select #(
    parameter int HICCUP_CYCLES = rail_fault_pkg::HICCUP_CYCLES,
    parameter logic [6:0] DEV_ADDR = rail_fault_pkg::PMBUS_DEV_ADDR
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_pin,
    input wire logic sda_pin_in,
    output logic sda_pin_out,
    output logic sda_oe_n,
    input wire logic ov_detect,
    input wire logic uv_detect,
    input wire logic pwm_en,
    input wire logic chip_en,
    input wire logic write_protect,
    input wire logic indiv_resp_en,
    input wire logic [1:0] mode_response,
    output logic pwm_run,
    output logic fault_flag_n,
    output logic [1:0] rail_status,
    output logic [7:0] flyback_resp_ctrl
);
    typedef enum logic [1:0] {SW_RUN, SW_HICCUP, SW_LATCHED} sw_t;
    typedef struct packed {
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [7:0] pin_s3;
        logic [7:0] pin_f;
        logic [7:0] resp_ctrl;
        logic [7:0] flyback_ctrl;
        logic [1:0] status;
        sw_t st;
        logic [31:0] cnt;
        logic run;
        logic flag_n;
        logic sda_level;
    } state_t;

    state_t s;
    state_t next_s;
    pmbus_reg_if bus ();

    logic ov;
    logic uv;
    logic en_ok;
    logic wp;
    logic indiv;
    logic [1:0] mode_code;
    logic [1:0] ov_code;
    logic [1:0] uv_code;
    logic hold;
    logic latch_hit;
    logic [1:0] stat_set;

    // code 11 folds onto flag only
    function automatic logic [1:0] pick_code(input logic ind, input logic [1:0] field,
        input logic [1:0] mode);
        logic [1:0] c;
        c = ind ? field : mode;
        if (c == rail_fault_pkg::CODE_FLAG_ALT) begin
            c = rail_fault_pkg::CODE_FLAG;
        end
        return c;
    endfunction

    pmbus_byte_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bus(bus)
    );

    assign bus.scl_in = scl_pin;
    assign bus.sda_in = sda_pin_in;
    assign sda_oe_n = bus.sda_oe_n;
    assign sda_pin_out = s.sda_level;
    assign pwm_run = s.run;
    assign fault_flag_n = s.flag_n;
    assign rail_status = s.status;
    assign flyback_resp_ctrl = s.flyback_ctrl;

    // pin vector: 7 ov, 6 uv, 5 pwm_en, 4 chip_en, 3 wp, 2 indiv, 1:0 mode
    assign ov = s.pin_f[7];
    assign uv = s.pin_f[6];
    assign en_ok = s.pin_f[5] & s.pin_f[4];
    assign wp = s.pin_f[3];
    assign indiv = s.pin_f[2];
    assign mode_code = s.pin_f[1:0];
    assign ov_code = pick_code(indiv, s.resp_ctrl[rail_fault_pkg::SIX_OV_LSB +: 2],
        mode_code);
    assign uv_code = pick_code(indiv, s.resp_ctrl[rail_fault_pkg::SIX_UV_LSB +: 2],
        mode_code);
    assign hold = (ov && ov_code != rail_fault_pkg::CODE_FLAG)
        || (uv && uv_code != rail_fault_pkg::CODE_FLAG);
    assign latch_hit = (ov && ov_code == rail_fault_pkg::CODE_LATCH)
        || (uv && uv_code == rail_fault_pkg::CODE_LATCH);

    always_comb begin
        case (bus.addr)
            rail_fault_pkg::ADDR_RESP_CTRL: bus.rdata = s.resp_ctrl;
            rail_fault_pkg::ADDR_FLYBACK_CTRL: bus.rdata = s.flyback_ctrl;
            rail_fault_pkg::ADDR_RAIL_STATUS: bus.rdata = {6'h00, s.status};
            default: bus.rdata = rail_fault_pkg::UNMAPPED_READ;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.pin_s1 = {ov_detect, uv_detect, pwm_en, chip_en, write_protect,
            indiv_resp_en, mode_response};
        next_s.pin_s2 = s.pin_s1;
        next_s.pin_s3 = s.pin_s2;
        next_s.pin_f = (s.pin_s2 & ~(s.pin_s2 ^ s.pin_s3)) | (s.pin_f & (s.pin_s2 ^ s.pin_s3));
        stat_set = 2'h0;
        stat_set[rail_fault_pkg::STAT_SIX_OV_BIT] = ov;
        stat_set[rail_fault_pkg::STAT_SIX_UV_BIT] = uv;
        if (bus.wr && !wp) begin
            case (bus.addr)
                rail_fault_pkg::ADDR_RESP_CTRL: next_s.resp_ctrl = bus.wdata;
                rail_fault_pkg::ADDR_FLYBACK_CTRL:
                    next_s.flyback_ctrl = bus.wdata & rail_fault_pkg::FLYBACK_CTRL_WMASK;
                rail_fault_pkg::ADDR_RAIL_STATUS: next_s.status = s.status & ~bus.wdata[1:0];
                default: next_s.status = s.status;
            endcase
        end
        next_s.status = next_s.status | stat_set;
        case (s.st)
            SW_RUN: begin
                if (latch_hit) begin
                    next_s.st = SW_LATCHED;
                end else if (hold) begin
                    next_s.st = SW_HICCUP;
                    next_s.cnt = 32'h0;
                end
            end
            SW_HICCUP: begin
                if (latch_hit) begin
                    next_s.st = SW_LATCHED;
                end else if (hold) begin
                    next_s.cnt = 32'h0;
                end else if (s.cnt >= 32'(HICCUP_CYCLES - 1)) begin
                    next_s.st = SW_RUN;
                end else begin
                    next_s.cnt = s.cnt + 32'h1;
                end
            end
            SW_LATCHED: begin
                // a latch-off fault still present keeps the latch closed
                if (!en_ok && !latch_hit) begin
                    next_s.st = SW_RUN;
                end
            end
            default: next_s.st = SW_RUN;
        endcase
        next_s.run = (next_s.st == SW_RUN) && en_ok;
        next_s.flag_n = ~|next_s.status;
        next_s.sda_level = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{pin_s1: 8'h00, pin_s2: 8'h00, pin_s3: 8'h00, pin_f: 8'h00,
                resp_ctrl: rail_fault_pkg::RESP_CTRL_RESET,
                flyback_ctrl: rail_fault_pkg::FLYBACK_CTRL_RESET,
                status: 2'h0, st: SW_RUN, cnt: 32'h0, run: 1'b0, flag_n: 1'b1,
                sda_level: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    a_ov_field_pick: assert property (@(posedge clk_sys) disable iff (!rst_n)
        indiv |-> ov_code == pick_code(1'b1, s.resp_ctrl[5:4], 2'h0))
        else $error("overvoltage code not taken from control bits");
    a_mode_pin_pick: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !indiv |-> (ov_code == uv_code) && (ov_code == pick_code(1'b0, 2'h0, mode_code)))
        else $error("mode pin not used when individual control is off");
    a_ov_status_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ov |=> s.status[0] && !fault_flag_n)
        else $error("overvoltage did not set status and flag");
    a_flag_keeps_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s.st == SW_RUN && en_ok && ov_code == 2'h0 && !uv) |=> pwm_run)
        else $error("flag-only overvoltage stopped switching");
    a_hiccup_stops: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ov && ov_code == 2'h1 && !latch_hit && s.st != SW_LATCHED)
        |=> s.st == SW_HICCUP && !pwm_run)
        else $error("hiccup overvoltage kept switching");
    a_uv_status_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        uv |=> s.status[1])
        else $error("undervoltage did not set status bit 1");
    a_hiccup_resume: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s.st == SW_HICCUP && !hold && !latch_hit && s.cnt >= 32'(HICCUP_CYCLES - 1))
        |=> s.st == SW_RUN)
        else $error("hiccup did not restart after the delay");
    a_latch_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s.st == SW_LATCHED && en_ok) |=> (s.st == SW_LATCHED && !pwm_run))
        else $error("latch-off released without an enable toggle");
    a_latch_enter: assert property (@(posedge clk_sys) disable iff (!rst_n)
        latch_hit |=> s.st == SW_LATCHED)
        else $error("latch-off fault did not latch");
    a_flyback_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s.flyback_ctrl & 8'h4C) == 8'h00)
        else $error("reserved flyback bits set");
    a_protect_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bus.wr && wp) |=> $stable(s.resp_ctrl))
        else $error("protected register changed");
    a_delay_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s.st == SW_HICCUP && hold && !latch_hit) |=> s.cnt == 32'h0)
        else $error("restart delay not cleared by returning fault");
    a_uv_hiccup_stops: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (uv && uv_code == rail_fault_pkg::CODE_HICCUP && !latch_hit && s.st != SW_LATCHED)
        |=> s.st == SW_HICCUP && !pwm_run)
        else $error("hiccup undervoltage kept switching");
    a_flag_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s.status != 2'h0) |-> !fault_flag_n)
        else $error("fault flag high while a status bit is set");
    a_run_needs_en: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !en_ok |=> !pwm_run)
        else $error("switching allowed with an enable low");
    a_hiccup_no_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s.st == SW_HICCUP) |-> !pwm_run)
        else $error("switching during hiccup wait");
    a_uv_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s.status[1] && !(bus.wr && bus.addr == rail_fault_pkg::ADDR_RAIL_STATUS))
        |=> s.status[1])
        else $error("undervoltage status lost without a clear");
    a_code11_runs: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (indiv && s.resp_ctrl[5:4] == 2'h3 && ov && !uv && s.st == SW_RUN && en_ok)
        |=> pwm_run)
        else $error("code 11 overvoltage stopped switching");
    a_ctrl_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bus.wr && !wp && bus.addr == rail_fault_pkg::ADDR_RESP_CTRL)
        |=> s.resp_ctrl == $past(bus.wdata))
        else $error("unprotected control write not stored");
    a_fly_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bus.wr && !wp && bus.addr == rail_fault_pkg::ADDR_FLYBACK_CTRL)
        |=> s.flyback_ctrl == ($past(bus.wdata) & 8'hB3))
        else $error("flyback control write not stored");
endmodule

// File: verification/pmbus_host_model.sv
// pmbus host model: bit-level register writes and reads toward the device
`timescale 1ns/1ns
module pmbus_host_model #(
    parameter logic [6:0] DEV_ADDR = rail_fault_pkg::PMBUS_DEV_ADDR
) (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_o
);
    initial begin
        scl = 1'b1;
        sda_o = 1'b1;
    end

    // one scl phase, above the 5-clock minimum
    task automatic half();
        repeat (8) @(negedge clk_sys);
    endtask

    // start or repeated start, entered with scl low or idle
    task automatic start_cond();
        sda_o = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_o = 1'b0;
        half();
        scl = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic stop_cond();
        sda_o = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_o = 1'b1;
        half();
    endtask

    // data moves only with scl low, sampled at the end of the high phase
    task automatic bit_cycle(input logic b, output logic got);
        sda_o = b;
        half();
        scl = 1'b1;
        half();
        got = sda_line;
        scl = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
        output logic ack_bit);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(tx[i], rx[i]);
        end
        bit_cycle(ack_in, ack_bit);
    endtask

    task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data, output logic ok);
        logic [7:0] rx;
        logic [2:0] a;
        start_cond();
        xfer({DEV_ADDR, 1'b0}, 1'b1, rx, a[0]);
        xfer(cmd, 1'b1, rx, a[1]);
        xfer(data, 1'b1, rx, a[2]);
        stop_cond();
        ok = (a === 3'h0);
    endtask

    // master ends the read with a nack before stop
    task automatic read_reg(input logic [7:0] cmd, output logic [7:0] data, output logic ok);
        logic [7:0] rx;
        logic [3:0] a;
        start_cond();
        xfer({DEV_ADDR, 1'b0}, 1'b1, rx, a[0]);
        xfer(cmd, 1'b1, rx, a[1]);
        start_cond();
        xfer({DEV_ADDR, 1'b1}, 1'b1, rx, a[2]);
        xfer(8'hFF, 1'b1, data, a[3]);
        stop_cond();
        ok = (a[2:0] === 3'h0);
    endtask
endmodule

// File: verification/rail_fault_response_select_tb.sv
// self-checking bench for the rail fault response block
`timescale 1ns/1ns
module rail_fault_response_select_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic ov_detect = 1'b0;
    logic uv_detect = 1'b0;
    logic pwm_en = 1'b1;
    logic chip_en = 1'b1;
    logic write_protect = 1'b0;
    logic indiv_resp_en = 1'b1;
    logic [1:0] mode_response = 2'h0;
    logic scl, sda_o, sda_line, sda_pin_out, sda_oe_n, pwm_run, fault_flag_n;
    logic [1:0] rail_status;
    logic [7:0] flyback_resp_ctrl;
    int num_errors = 0;
    int n_compared = 0;

    always #5 clk_sys = ~clk_sys;
    // open-drain data line with pull-up
    assign sda_line = sda_o & (sda_oe_n | sda_pin_out);

    rail_fault_response_select #(.HICCUP_CYCLES(20)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .scl_pin(scl), .sda_pin_in(sda_line), .sda_pin_out(sda_pin_out), .sda_oe_n(sda_oe_n),
        .ov_detect(ov_detect), .uv_detect(uv_detect), .pwm_en(pwm_en), .chip_en(chip_en),
        .write_protect(write_protect), .indiv_resp_en(indiv_resp_en),
        .mode_response(mode_response), .pwm_run(pwm_run), .fault_flag_n(fault_flag_n),
        .rail_status(rail_status), .flyback_resp_ctrl(flyback_resp_ctrl));
    pmbus_host_model i_host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_o(sda_o));

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t register got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_out(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t output got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic clocks(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
        logic ok;
        i_host.write_reg(cmd, data, ok);
        check_reg({7'h00, ok}, 8'h01);
    endtask

    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] data;
        logic ok;
        i_host.read_reg(cmd, data, ok);
        check_reg({7'h00, ok}, 8'h01);
        check_reg(data, exp);
    endtask

    // raise one rail fault, release it, and check the chosen reaction
    task automatic fault_case(input logic uv, input logic [1:0] eff);
        logic stops;
        stops = (eff == rail_fault_pkg::CODE_HICCUP) || (eff == rail_fault_pkg::CODE_LATCH);
        ov_detect = ~uv;
        uv_detect = uv;
        clocks(12);
        check_out({6'h00, rail_status}, uv ? 8'h02 : 8'h01);
        check_out({7'h00, fault_flag_n}, 8'h00);
        check_out({7'h00, pwm_run}, {7'h00, ~stops});
        if (eff == rail_fault_pkg::CODE_HICCUP) begin
            ov_detect = 1'b0;
            uv_detect = 1'b0;
            clocks(10);
            ov_detect = ~uv;
            uv_detect = uv;
            clocks(6);
        end
        ov_detect = 1'b0;
        uv_detect = 1'b0;
        clocks(15);
        check_out({7'h00, pwm_run}, {7'h00, ~stops});
        clocks(25);
        check_out({7'h00, pwm_run}, {7'h00, eff != rail_fault_pkg::CODE_LATCH});
        if (eff == rail_fault_pkg::CODE_LATCH) begin
            if (uv) chip_en = 1'b0; else pwm_en = 1'b0;
            clocks(10);
            chip_en = 1'b1;
            pwm_en = 1'b1;
            clocks(10);
            check_out({7'h00, pwm_run}, 8'h01);
        end
        wr(rail_fault_pkg::ADDR_RAIL_STATUS, 8'h03);
        check_out({5'h00, fault_flag_n, rail_status}, 8'h04);
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        num_errors++;
        $display("[FAIL] t=%0t run limit reached", $time);
        wrap_up();
    end

    initial begin
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        clocks(10);
        check_out({5'h00, fault_flag_n, rail_status}, 8'h04);
        check_out({7'h00, pwm_run}, 8'h01);
        rd(rail_fault_pkg::ADDR_RESP_CTRL, 8'h00);
        rd(rail_fault_pkg::ADDR_FLYBACK_CTRL, 8'h00);
        $display("test reset_values done");
        wr(rail_fault_pkg::ADDR_FLYBACK_CTRL, 8'hFF);
        rd(rail_fault_pkg::ADDR_FLYBACK_CTRL, 8'hB3);
        check_out(flyback_resp_ctrl, 8'hB3);
        write_protect = 1'b1;
        clocks(5);
        wr(rail_fault_pkg::ADDR_RESP_CTRL, 8'h55);
        rd(rail_fault_pkg::ADDR_RESP_CTRL, 8'h00);
        write_protect = 1'b0;
        clocks(5);
        wr(rail_fault_pkg::ADDR_RESP_CTRL, 8'hA5);
        rd(rail_fault_pkg::ADDR_RESP_CTRL, 8'hA5);
        rd(8'h77, 8'h00);
        $display("test registers done");
        for (int k = 0; k < 8; k++) begin
            wr(rail_fault_pkg::ADDR_RESP_CTRL, {6'h00, k[1:0]} << (k[2] ? 6 : 4));
            fault_case(k[2], k[1:0]);
        end
        $display("test field_codes done");
        wr(rail_fault_pkg::ADDR_RESP_CTRL, 8'hA0);
        indiv_resp_en = 1'b0;
        for (int k = 0; k < 8; k++) begin
            mode_response = k[1:0];
            clocks(6);
            fault_case(k[2], k[1:0]);
        end
        $display("test mode_pin done");
        wrap_up();
    end
endmodule
